// *** dv/mtc_radio_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Radio side: one outcome a set delay after each launch, none if aborted or sel is 3
module mtc_radio_model (
  input  wire logic       pclk,     // Clock
  input  wire logic       presetn,  // Reset, low
  input  wire logic       tx_go,    // Launch pulse
  input  wire logic       tx_abort, // Abort pulse
  input  wire logic       collision_avoid_enable, // Access on
  input  wire logic [1:0] sel,      // 0 ok, 1 busy air, 2 no ack
  input  wire logic [7:0] dly,      // Cycles to outcome
  output logic            tx_success,   // Sent pulse
  output logic            tx_csma_fail, // Access fail pulse
  output logic            tx_no_ack,    // No ack pulse
  output logic            csma_active   // Access running
);
  logic       busy_q;
  logic [7:0] cnt_q;
  logic       fire;

  // Count down from launch, stop on abort or outcome
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
    end
    else if (tx_go)
    begin
      busy_q <= 1'b1;
      cnt_q  <= dly;
    end
    else if (tx_abort || fire)
      busy_q <= 1'b0;
    else if (busy_q)
      cnt_q <= cnt_q - 8'h01;
  end

  assign fire         = busy_q && (cnt_q == 8'h00);
  assign csma_active  = busy_q && collision_avoid_enable;
  assign tx_success   = fire && (sel == 2'h0);
  assign tx_csma_fail = fire && (sel == 2'h1);
  assign tx_no_ack    = fire && (sel == 2'h2);
endmodule : mtc_radio_model

// *** dv/mtc_txrx_checker.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port checker for the transmit and receive control
module mtc_txrx_checker
  import mtc_pkg::*;
(
  input wire logic       pclk,               // Clock
  input wire logic       presetn,            // Reset, low
  input wire logic       tx_success,         // Sent pulse
  input wire logic       tx_csma_fail,       // Access fail
  input wire logic       tx_no_ack,          // No ack
  input wire logic       tx_frame_ack_req,   // Ack asked
  input wire logic       rx_busy,            // Receiving
  input wire logic       ack_tx_busy,        // Ack on air
  input wire logic       csma_active,        // Access running
  input wire logic       tx_go,              // Launch
  input wire logic       tx_abort,           // Abort
  input wire logic       transmit_start_bit, // Busy bit
  input wire logic       auto_ack_enable,    // Auto ack
  input wire logic [1:0] transceiver_mode,   // Mode
  input wire logic       receive_enable_bit, // Rx on
  input wire logic       rx_abort,           // Rx drop
  input wire logic       ack_abort,          // Ack stop
  input wire logic       radio_rx_on,        // Radio rx
  input wire logic [4:0] status_flags        // Flags
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Properties
  property p_go;
    $rose(transmit_start_bit) |-> tx_go;
  endproperty
  a_go: assert property (p_go) else $error("no launch");
  property p_done;
    tx_success && transmit_start_bit |=> status_flags[0]
      && (transmit_start_bit || status_flags[1]);
  endproperty
  a_done: assert property (p_done) else $error("done");
  property p_csma;
    tx_csma_fail && !tx_success && transmit_start_bit
      |=> !transmit_start_bit && status_flags[2];
  endproperty
  a_csma: assert property (p_csma) else $error("csma");
  property p_nak;
    tx_no_ack && !tx_success && !tx_csma_fail && transmit_start_bit
      && tx_frame_ack_req && auto_ack_enable
      |=> !transmit_start_bit && status_flags[3];
  endproperty
  a_nak: assert property (p_nak) else $error("no ack");
  property p_abort;
    tx_abort |-> !transmit_start_bit && $past(transmit_start_bit);
  endproperty
  a_abort: assert property (p_abort) else $error("abort");
  property p_hc;
    $fell(transmit_start_bit) && !tx_abort
      |-> $past(tx_success || tx_csma_fail || tx_no_ack);
  endproperty
  a_hc: assert property (p_hc) else $error("clear no flag");
  property p_rxab;
    $fell(receive_enable_bit) && $past(rx_busy) |-> rx_abort;
  endproperty
  a_rxab: assert property (p_rxab) else $error("rx drop");
  property p_ackab;
    $fell(receive_enable_bit) && $past(ack_tx_busy) |-> ack_abort;
  endproperty
  a_ackab: assert property (p_ackab) else $error("ack stop");
  property p_radio;
    csma_active |=> radio_rx_on;
  endproperty
  a_radio: assert property (p_radio) else $error("radio");
  property p_mode;
    $changed(transceiver_mode) && transceiver_mode == MODE_TX_STRM
      |-> ##[0:1] !receive_enable_bit;
  endproperty
  a_mode: assert property (p_mode) else $error("mode");

  // Main scenarios
  c_done: cover property (tx_success && transmit_start_bit);
  c_rxab: cover property (rx_abort);
  c_abort: cover property (tx_abort);
endmodule : mtc_txrx_checker

bind mtc_txrx_ctrl mtc_txrx_checker chk_u (.pclk(pclk),
  .presetn(presetn), .tx_success(tx_success),
  .tx_csma_fail(tx_csma_fail), .tx_no_ack(tx_no_ack),
  .tx_frame_ack_req(tx_frame_ack_req), .rx_busy(rx_busy),
  .ack_tx_busy(ack_tx_busy), .csma_active(csma_active),
  .tx_go(tx_go), .tx_abort(tx_abort),
  .transmit_start_bit(transmit_start_bit),
  .auto_ack_enable(auto_ack_enable),
  .transceiver_mode(transceiver_mode),
  .receive_enable_bit(receive_enable_bit), .rx_abort(rx_abort),
  .ack_abort(ack_abort), .radio_rx_on(radio_rx_on),
  .status_flags(status_flags));

// *** dv/test_mtc_txrx_ctrl.sv ***
`timescale 1ns/1ps
module test_mtc_txrx_ctrl;
  import mtc_pkg::*;
  // ==========================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        suc, csf, nak, ack_req, buf_wr, busy, fr_end, e;
  logic        tx_go, tx_abort, start, cae, csa, rx_en, we;
  logic        tbe, aw, rab, aab, aae, rro;
  logic [7:0]  lqi, rssi, wdat, dly;
  logic [3:0]  chan, rtc;
  logic [2:0]  rate, drc;
  logic [1:0]  sel, tmd;
  logic [4:0]  stf;
  logic [7:0]  trl_q[$];
  int          bad_count, total_checks, go_cnt, g0, ab_cnt;

  mtc_txrx_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_success(suc), .tx_csma_fail(csf),
    .tx_no_ack(nak), .tx_frame_ack_req(ack_req),
    .transmit_buffer_empty(tbe), .host_buf_wr(buf_wr),
    .rx_busy(busy), .ack_tx_busy(busy), .csma_active(csa),
    .ack_wait(aw), .rx_frame_end(fr_end), .rx_lqi(lqi),
    .rx_rssi(rssi), .rx_mac_type(1'b1), .rx_rate(rate),
    .tx_go(tx_go), .tx_abort(tx_abort), .transmit_start_bit(start),
    .collision_avoid_enable(cae), .auto_ack_enable(aae),
    .retransmit_count(rtc), .data_rate_code(drc), .chan_code(chan),
    .transceiver_mode(tmd), .receive_enable_bit(rx_en),
    .rx_abort(rab), .ack_abort(aab), .radio_rx_on(rro), .buf_we(we),
    .buf_wdata(wdat), .status_flags(stf));

  mtc_radio_model radio_u (.pclk(pclk), .presetn(presetn),
    .tx_go(tx_go), .tx_abort(tx_abort), .collision_avoid_enable(cae),
    .sel(sel), .dly(dly), .tx_success(suc), .tx_csma_fail(csf),
    .tx_no_ack(nak), .csma_active(csa));

  // Clock and monitors
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (we === 1'b1) trl_q.push_back(wdat);
  always @(posedge pclk) if (tx_go === 1'b1) go_cnt++;
  always @(posedge pclk) if (rab === 1'b1 && aab === 1'b1) ab_cnt++;

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
    total_checks++;
    if (seen !== ex)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, ex);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 8'h00);
    chk(r, ex);
  endtask : rd

  task automatic frame();
    trl_q.delete();
    fr_end <= 1'b1;
    @(posedge pclk);
    fr_end <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask : frame

  task automatic wt();
    while (start !== 1'b0)
      @(posedge pclk);
  endtask : wt

  task automatic close_out();
    $display("Checks %0d, errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // ==========================================================
  // Watchdog
  initial
  begin
    #200us;
    bad_count++;
    close_out();
  end

  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ack_req, buf_wr, busy, fr_end, sel, tbe, aw} = '0;
    {lqi, rssi, rate, dly} = {8'hA5, 8'h3C, 3'h5, 8'h20};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h048, 32'h0B);
    chk({cae, drc}, 32'hB);
    tbe <= 1'b1;
    rd(12'h048, 32'h1B);
    tbe <= 1'b0;
    rd(12'h0FC, 32'h00);
    chk(e, 1'b1);
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, 12'h044, 8'(c << 4));
      rd(12'h044, 32'(c << 4));
      chk(chan, 32'(c));
    end
    apb(1'b1, 12'h054, 8'h1C);
    apb(1'b1, 12'h054, 8'h9C);
    frame();
    chk(trl_q.size(), 3);
    chk({trl_q[0], trl_q[1], trl_q[2]}, 32'hA53CFD);
    apb(1'b1, 12'h054, 8'h1C);
    apb(1'b1, 12'h054, 8'h04);
    apb(1'b1, 12'h054, 8'h84);
    frame();
    chk({8'(trl_q.size()), trl_q[0]}, 32'h1FD);
    busy <= 1'b1;
    apb(1'b1, 12'h054, 8'h04);
    apb(1'b1, 12'h054, 8'h00);
    busy <= 1'b0;
    chk(ab_cnt, 1);
    apb(1'b1, 12'h054, 8'h80);
    apb(1'b1, 12'h100, 8'h02);
    rd(12'h054, 32'h00);
    apb(1'b1, 12'h100, 8'h01);
    rd(12'h054, 32'h80);
    apb(1'b1, 12'h054, 8'h00);
    chk(rro, 1'b0);
    aw <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(rro, 1'b1);
    aw <= 1'b0;
    apb(1'b1, 12'h100, 8'h34);
    rd(12'h100, 32'h34);
    chk({aae, rtc, tmd}, 32'h4C);
    ack_req <= 1'b1;
    for (int o = 0; o < 3; o++)
    begin
      sel <= 2'(o);
      g0 = go_cnt;
      apb(1'b1, 12'h048, 8'h8B);
      rd(12'h048, 32'h8B);
      apb(1'b1, 12'h048, 8'h8B);
      wt();
      chk(go_cnt - g0, 1);
      rd(12'h104, 32'(o == 0 ? 3 : 2 << o));
      apb(1'b1, 12'h104, 8'h1F);
    end
    apb(1'b1, 12'h100, 8'h02);
    sel <= 2'h0;
    g0 = go_cnt;
    apb(1'b1, 12'h048, 8'h8B);
    apb(1'b1, 12'h048, 8'h8B);
    buf_wr <= 1'b1;
    @(posedge pclk);
    buf_wr <= 1'b0;
    wt();
    chk(go_cnt - g0, 2);
    rd(12'h104, 32'h03);
    apb(1'b1, 12'h104, 8'h1F);
    apb(1'b1, 12'h048, 8'h8B);
    buf_wr <= 1'b1;
    @(posedge pclk);
    buf_wr <= 1'b0;
    apb(1'b1, 12'h048, 8'h0B);
    rd(12'h048, 32'h0B);
    repeat (40) @(posedge pclk);
    rd(12'h104, 32'h10);
    chk(stf, 32'h10);
    close_out();
  end
endmodule : test_mtc_txrx_ctrl

// *** verilog/mtc_pkg.sv ***
package mtc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CHAN_SEC  = 8'h11;
  localparam logic [7:0] IDX_TX_CTRL   = 8'h12;
  localparam logic [7:0] IDX_RX_CTRL1  = 8'h15;
  localparam logic [7:0] IDX_MODE      = 8'h40;
  localparam logic [7:0] IDX_STATUS    = 8'h41;

  // ==========================================================
  // Field positions
  localparam int CHAN_LSB       = 4;
  localparam int TX_START_BIT   = 7;
  localparam int TX_BUF_EMPTY_BIT = 4;
  localparam int CSMA_EN_BIT    = 3;
  localparam int RX_EN_BIT      = 7;
  localparam int APP_LQI_BIT    = 4;
  localparam int APP_RSSI_BIT   = 3;
  localparam int APP_CTR_BIT    = 2;
  localparam int AUTO_ACK_BIT   = 2;
  localparam int RETX_LSB       = 4;
  localparam int ST_DONE_BIT    = 0;
  localparam int ST_IDLE_BIT    = 1;
  localparam int ST_CSMA_BIT    = 2;
  localparam int ST_ACK_BIT     = 3;
  localparam int ST_OVF_BIT     = 4;

  // ==========================================================
  // Reset values and mode codes
  localparam logic [2:0] DATA_RATE_RST = 3'h3;
  localparam logic       CSMA_EN_RST   = 1'h1;
  localparam logic [1:0] MODE_PACKET   = 2'h0;
  localparam logic [1:0] MODE_RX_STRM  = 2'h1;
  localparam logic [1:0] MODE_TX_STRM  = 2'h2;

  typedef enum logic [1:0] {TRL_IDLE, TRL_LQI, TRL_RSSI, TRL_CTR} mtc_trl_t;

  // ==========================================================
  // Whole state of the block
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [3:0]  chan;
    logic        tx_start;
    logic        pending;
    logic        csma_en;
    logic [2:0]  data_rate;
    logic        rx_en;
    logic        app_lqi;
    logic        app_rssi;
    logic        app_ctr;
    logic [1:0]  trx_mode;
    logic        auto_ack;
    logic [3:0]  retx_cnt;
    logic [4:0]  flags;
    logic        tx_go;
    logic        tx_abort;
    logic        rx_abort;
    logic        ack_abort;
    logic        radio_rx_on;
    mtc_trl_t    trl;
    logic [7:0]  lqi;
    logic [7:0]  rssi;
    logic [7:0]  ctr;
    logic        buf_we;
    logic [7:0]  buf_wdata;
  } mtc_state_t;

endpackage : mtc_pkg

// *** verilog/mtc_txrx_ctrl.sv ***
// Our own choice: the APB register port.
`timescale 1ns/1ps

// Overview of operation
// - LQI byte appended when its enable set
// - RSSI byte appended when its enable set
// - Channel, MAC type, rate byte appended
// - Host writes one to start transmit
// - Writing zero aborts any transmit activity
// - Success sets done; without pending clears start, sets idle
// - Channel access failure clears start, flags
// - Missing acknowledgement clears start, flags
// - Transmit streaming repeat start posts pending start
// - Overflow untouched when start and pending
// - Repeat start ignored outside transmit streaming mode
// - Start bit readable, shows transmit busy
// - Transmit runs configured access, rate, auto ack, retries
// - Channel field selects operating channel
// - Receive enable gates reception, clear aborts
// - Mode change clears or sets receive enable
// - Receive enable clear aborts auto acknowledgement
// - Channel check and ack receive force radio
module mtc_txrx_ctrl (
  input  wire logic        pclk,             // Bus clock
  input  wire logic        presetn,          // Async reset, low
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB direction
  input  wire logic [11:0] paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error
  input  wire logic        tx_success,       // Frame sent, retries over
  input  wire logic        tx_csma_fail,     // Channel access failed
  input  wire logic        tx_no_ack,        // Retries spent, no ack
  input  wire logic        tx_frame_ack_req, // Frame asks for ack
  input  wire logic        transmit_buffer_empty, // Tx buffer empty
  input  wire logic        host_buf_wr,      // Host wrote packet buffer
  input  wire logic        rx_busy,          // Frame being received
  input  wire logic        ack_tx_busy,      // Auto ack on air
  input  wire logic        csma_active,      // Channel check running
  input  wire logic        ack_wait,         // Waiting for ack frame
  input  wire logic        rx_frame_end,     // Received frame ended
  input  wire logic [7:0]  rx_lqi,           // Measured link quality
  input  wire logic [7:0]  rx_rssi,          // Measured strength
  input  wire logic        rx_mac_type,      // MAC type of frame
  input  wire logic [2:0]  rx_rate,          // Rate of frame
  output logic             tx_go,            // Launch transmit, pulse
  output logic             tx_abort,         // Abort transmit, pulse
  output logic             transmit_start_bit, // Transmit in progress
  output logic             collision_avoid_enable, // Use channel access
  output logic             auto_ack_enable,  // Auto ack on
  output logic      [3:0]  retransmit_count, // Retry limit
  output logic      [2:0]  data_rate_code,   // Transmit rate
  output logic      [3:0]  chan_code,        // Operating channel
  output logic      [1:0]  transceiver_mode, // Packet/stream mode
  output logic             receive_enable_bit, // Reception enabled
  output logic             rx_abort,         // Drop frame, pulse
  output logic             ack_abort,        // Stop ack, pulse
  output logic             radio_rx_on,      // Radio to receive
  output logic             buf_we,           // Trailer byte write
  output logic      [7:0]  buf_wdata,        // Trailer byte
  output logic      [4:0]  status_flags      // Outcome flags
);
  import mtc_pkg::*;

  mtc_state_t s_q;
  mtc_state_t s_d;

  // Index match for an aligned word address
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
  endfunction : hit

  logic       acc;
  logic       wr;
  logic       mapped;
  logic [7:0] wb;
  logic [7:0] set_f;
  logic [7:0] rd;

  // ==========================================================
  // APB decode
  assign acc = psel & penable & s_q.pready;
  assign wr  = acc & pwrite;
  assign wb  = pwdata[7:0];
  assign mapped = hit(paddr, IDX_CHAN_SEC) | hit(paddr, IDX_TX_CTRL) |
                  hit(paddr, IDX_RX_CTRL1) | hit(paddr, IDX_MODE) |
                  hit(paddr, IDX_STATUS);

  // Read data mux
  always_comb
  begin
    rd = 8'h00;
    if (hit(paddr, IDX_CHAN_SEC))
      rd[CHAN_LSB +: 4] = s_q.chan;
    if (hit(paddr, IDX_TX_CTRL))
    begin
      rd[TX_START_BIT]     = s_q.tx_start;
      rd[TX_BUF_EMPTY_BIT] = transmit_buffer_empty;
      rd[CSMA_EN_BIT]      = s_q.csma_en;
      rd[2:0]              = s_q.data_rate;
    end
    if (hit(paddr, IDX_RX_CTRL1))
    begin
      rd[RX_EN_BIT]    = s_q.rx_en;
      rd[APP_LQI_BIT]  = s_q.app_lqi;
      rd[APP_RSSI_BIT] = s_q.app_rssi;
      rd[APP_CTR_BIT]  = s_q.app_ctr;
    end
    if (hit(paddr, IDX_MODE))
      rd = {s_q.retx_cnt, 1'h0, s_q.auto_ack, s_q.trx_mode};
    if (hit(paddr, IDX_STATUS))
      rd = {3'h0, s_q.flags};
  end

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    s_d = s_q;
    set_f = 8'h00;
    s_d.tx_go     = 1'b0;
    s_d.tx_abort  = 1'b0;
    s_d.rx_abort  = 1'b0;
    s_d.ack_abort = 1'b0;
    s_d.buf_we    = 1'b0;

    // Bus answer: one wait state, then ready
    s_d.pready  = psel & penable & ~s_q.pready;
    s_d.pslverr = psel & penable & ~s_q.pready & ~mapped;
    if (psel & penable & ~s_q.pready & ~pwrite)
      s_d.prdata = {24'h0, rd};

    // Transmit outcomes from the radio
    if (s_q.tx_start)
    begin
      if (tx_success)
      begin
        set_f[ST_DONE_BIT] = 1'b1;
        if (s_q.pending)
        begin
          s_d.pending = 1'b0;
          s_d.tx_go   = 1'b1;
        end
        else
        begin
          s_d.tx_start = 1'b0;
          set_f[ST_IDLE_BIT] = 1'b1;
        end
      end
      else if (tx_csma_fail)
      begin
        s_d.tx_start = 1'b0;
        s_d.pending  = 1'b0;
        set_f[ST_CSMA_BIT] = 1'b1;
      end
      // ack failure only when ack applies
      else if (tx_no_ack & tx_frame_ack_req & s_q.auto_ack)
      begin
        s_d.tx_start = 1'b0;
        s_d.pending  = 1'b0;
        set_f[ST_ACK_BIT] = 1'b1;
      end
    end

    // Overflow on buffer write while a frame is queued
    // held when start and posted start
    if (host_buf_wr & s_q.tx_start & ~transmit_buffer_empty &
        ~(s_q.tx_start & s_q.pending))
      set_f[ST_OVF_BIT] = 1'b1;

    // Register writes
    if (wr & hit(paddr, IDX_CHAN_SEC))
      s_d.chan = wb[CHAN_LSB +: 4];

    if (wr & hit(paddr, IDX_TX_CTRL))
    begin
      s_d.csma_en   = wb[CSMA_EN_BIT];
      s_d.data_rate = wb[2:0];
      if (wb[TX_START_BIT])
      begin
        if (~s_q.tx_start)
        begin
          s_d.tx_start = 1'b1;
          s_d.tx_go    = 1'b1;
        end
        else if (s_q.trx_mode == MODE_TX_STRM)
          s_d.pending = 1'b1;
      end
      else
      begin
        s_d.tx_abort = s_q.tx_start;
        s_d.tx_start = 1'b0;
        s_d.pending  = 1'b0;
      end
    end

    if (wr & hit(paddr, IDX_RX_CTRL1))
    begin
      s_d.rx_en    = wb[RX_EN_BIT];
      s_d.app_lqi  = wb[APP_LQI_BIT];
      s_d.app_rssi = wb[APP_RSSI_BIT];
      s_d.app_ctr  = wb[APP_CTR_BIT];
    end

    if (wr & hit(paddr, IDX_MODE))
    begin
      s_d.trx_mode = wb[1:0];
      s_d.auto_ack = wb[AUTO_ACK_BIT];
      s_d.retx_cnt = wb[RETX_LSB +: 4];
      if (wb[1:0] == MODE_TX_STRM)
        s_d.rx_en = 1'b0;
      else if (wb[1:0] == MODE_RX_STRM)
        s_d.rx_en = 1'b1;
    end

    s_d.rx_abort  = s_q.rx_en & ~s_d.rx_en & rx_busy;
    s_d.ack_abort = s_q.rx_en & ~s_d.rx_en & ack_tx_busy;

    // Status flags: write one clears, set wins
    if (wr & hit(paddr, IDX_STATUS))
      s_d.flags = s_q.flags & ~wb[4:0];
    s_d.flags = s_d.flags | set_f[4:0];

    // channel check and ack wait use receiver
    s_d.radio_rx_on = s_d.rx_en | csma_active | ack_wait;

    // Receive trailer sequencer
    case (s_q.trl)
      TRL_IDLE:
      begin
        if (rx_frame_end & s_q.rx_en)
        begin
          s_d.lqi  = rx_lqi;
          s_d.rssi = rx_rssi;
          s_d.ctr  = {s_q.chan, rx_mac_type, rx_rate};
          if (s_q.app_lqi)
            s_d.trl = TRL_LQI;
          else if (s_q.app_rssi)
            s_d.trl = TRL_RSSI;
          else if (s_q.app_ctr)
            s_d.trl = TRL_CTR;
        end
      end
      TRL_LQI:
      begin
        s_d.buf_we    = 1'b1;
        s_d.buf_wdata = s_q.lqi;
        if (s_q.app_rssi)
          s_d.trl = TRL_RSSI;
        else if (s_q.app_ctr)
          s_d.trl = TRL_CTR;
        else
          s_d.trl = TRL_IDLE;
      end
      TRL_RSSI:
      begin
        s_d.buf_we    = 1'b1;
        s_d.buf_wdata = s_q.rssi;
        s_d.trl = s_q.app_ctr ? TRL_CTR : TRL_IDLE;
      end
      TRL_CTR:
      begin
        s_d.buf_we    = 1'b1;
        s_d.buf_wdata = s_q.ctr;
        s_d.trl       = TRL_IDLE;
      end
      default:
        s_d.trl = TRL_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q           <= '0;
      s_q.trl       <= TRL_IDLE;
      s_q.csma_en   <= CSMA_EN_RST;
      s_q.data_rate <= DATA_RATE_RST;
      s_q.trx_mode  <= MODE_PACKET;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // Outputs straight from the state register
  // config handed to the transmit engine
  assign collision_avoid_enable = s_q.csma_en;
  assign auto_ack_enable        = s_q.auto_ack;
  assign retransmit_count       = s_q.retx_cnt;
  assign data_rate_code         = s_q.data_rate;
  assign prdata             = s_q.prdata;
  assign pready             = s_q.pready;
  assign pslverr            = s_q.pslverr;
  assign tx_go              = s_q.tx_go;
  assign tx_abort           = s_q.tx_abort;
  assign transmit_start_bit = s_q.tx_start;
  assign chan_code          = s_q.chan;
  assign transceiver_mode   = s_q.trx_mode;
  assign receive_enable_bit = s_q.rx_en;
  assign rx_abort           = s_q.rx_abort;
  assign ack_abort          = s_q.ack_abort;
  assign radio_rx_on        = s_q.radio_rx_on;
  assign buf_we             = s_q.buf_we;
  assign buf_wdata          = s_q.buf_wdata;
  assign status_flags       = s_q.flags;

endmodule : mtc_txrx_ctrl
